// file: hdl/exec_gate.sv
// routes the bytes of an execute command to the core, or drops one byte
// assumes the serial front end strips the command code and gives the length
`timescale 1ns/100ps
`default_nettype none
module exec_gate
    import ocd_ctrl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic exec_start,
    input wire logic [2:0] exec_len,
    input wire logic exec_allowed,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    output logic busy,
    output logic core_valid,
    output logic [7:0] core_byte,
    output logic core_last,
    output logic discarded
);
    typedef enum logic [1:0] {GATE_IDLE, GATE_DISCARD, GATE_FORWARD} gate_mode_t;
    typedef struct packed {
        gate_mode_t mode;
        logic [2:0] left;
        logic valid;
        logic [7:0] data;
        logic last;
        logic dropped;
    } gate_state_t;

    gate_state_t st_q, st_d;

    always_comb begin
        st_d = st_q;
        st_d.valid = 1'b0;
        st_d.last = 1'b0;
        st_d.dropped = 1'b0;
        case (st_q.mode)
            GATE_IDLE: begin
                if (exec_start) begin
                    st_d.mode = exec_allowed ? GATE_FORWARD : GATE_DISCARD; // R8
                    if (exec_len < EXEC_LEN_MIN) begin
                        st_d.left = EXEC_LEN_MIN;
                    end else if (exec_len > EXEC_LEN_MAX) begin
                        st_d.left = EXEC_LEN_MAX;
                    end else begin
                        st_d.left = exec_len;
                    end
                end
            end
            GATE_DISCARD: begin
                if (byte_valid) begin
                    st_d.dropped = 1'b1; // R8
                    st_d.mode = GATE_IDLE;
                end
            end
            GATE_FORWARD: begin
                if (byte_valid) begin
                    st_d.valid = 1'b1; // R1
                    st_d.data = byte_data;
                    st_d.left = st_q.left - 3'h1;
                    if (st_q.left == EXEC_LEN_MIN) begin
                        st_d.last = 1'b1;
                        st_d.mode = GATE_IDLE;
                    end
                end
            end
            default: st_d.mode = GATE_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '{mode: GATE_IDLE, left: 3'h0, valid: 1'b0, data: 8'h00,
                      last: 1'b0, dropped: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign busy = (st_q.mode != GATE_IDLE);
    assign core_valid = st_q.valid;
    assign core_byte = st_q.data;
    assign core_last = st_q.last;
    assign discarded = st_q.dropped;

    sequence s_refused_start;
        (st_q.mode == GATE_IDLE) && exec_start && !exec_allowed;
    endsequence
    sequence s_one_byte_dropped;
        (st_q.mode == GATE_DISCARD) && byte_valid;
    endsequence
    property p_refused_drops_one;
        @(posedge clk_sys) disable iff (!rst_b)
        s_refused_start ##[1:20] s_one_byte_dropped |=> discarded && !core_valid && !busy;
    endproperty
    a_refused_drops_one: assert property (p_refused_drops_one) else $error("refused exec not dropped"); // R8
    property p_no_forward_when_refused;
        @(posedge clk_sys) disable iff (!rst_b)
        s_refused_start |=> !core_valid [*2];
    endproperty
    a_no_forward_when_refused: assert property (p_no_forward_when_refused) else $error("refused exec reached core"); // R8
endmodule
`default_nettype wire

// file: hdl/irq_flags.sv
// sticky event flags, write-one-to-clear, with a mask and one level output
// assumes set and clear strobes are one-cycle pulses on clk_sys
`timescale 1ns/100ps
`default_nettype none
module irq_flags
    import ocd_ctrl_pkg::*;
#(
    parameter int W = EV_COUNT
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [W-1:0] event_set,
    input wire logic [W-1:0] clear_ones,
    input wire logic mask_write,
    input wire logic [W-1:0] mask_wdata,
    output logic [W-1:0] status,
    output logic [W-1:0] mask,
    output logic irq
);
    typedef struct packed {
        logic [W-1:0] status;
        logic [W-1:0] mask;
    } irq_state_t;

    irq_state_t st_q, st_d;

    always_comb begin
        st_d = st_q;
        // set wins over a clear in the same cycle
        st_d.status = (st_q.status & ~clear_ones) | event_set;
        if (mask_write) begin
            st_d.mask = mask_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign status = st_q.status;
    assign mask = st_q.mask;
    assign irq = |(st_q.status & st_q.mask);

    property p_set_sticks;
        @(posedge clk_sys) disable iff (!rst_b)
        (event_set != '0) |=> ((status & $past(event_set)) == $past(event_set));
    endproperty
    a_set_sticks: assert property (p_set_sticks) else $error("event flag not set");
endmodule
`default_nettype wire

// file: hdl/ocd_ctrl.sv
// debug state control: entry, exit, breakpoints, reset request, APB registers
// assumes an APB master on clk_sys, a core that stalls fetch on fetch_stop,
// a serial front end that decodes the execute command, all synchronous
//
// Functional notes
// [R1] in debug state fetch stops; core runs only debugger-fed instructions
// [R2] in debug state clock and peripherals run, except during stop mode
// [R3] entering debug state pulls the core out of halt mode
// [R4] in debug state the watchdog is refreshed continuously while enabled
// [R5] executing a breakpoint opcode with breakpoints allowed enters debug state
// [R6] debug pin low at end of reset enters debug state, larger packages only
// [R7] debugger keeps debug pin low 5000 more cycles after reset
// [R8] execute command outside debug state or under protection discards one byte
// [R9] control bit 7 set enters debug state; clearing it resumes execution
// [R10] hardware sets bit 7 when a breakpoint decodes with bit 6 set
// [R11] under read protection writes of 0 to bit 7 are ignored
// [R12] bit 6 clear makes opcode 00 a no-op; set makes it a breakpoint
// [R13] writing 1 to control bit 0 resets the whole device
// [R14] reserved control bits 4..1 read zero and ignore writes
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module ocd_ctrl
    import ocd_ctrl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // straps and options
    input wire logic debug_serial_pin_in,
    input wire logic large_package,
    input wire logic read_protect,
    // core status
    input wire logic opcode_decoded,
    input wire logic [7:0] opcode,
    input wire logic halt_mode,
    input wire logic stop_mode,
    input wire logic watchdog_enabled,
    // execute command from the serial front end
    input wire logic exec_start,
    input wire logic [2:0] exec_len,
    input wire logic exec_byte_valid,
    input wire logic [7:0] exec_byte,
    // core controls
    output logic fetch_stop,
    output logic core_idle,
    output logic core_exec_valid,
    output logic [7:0] core_exec_byte,
    output logic core_exec_last,
    output logic breakpoint_as_nop,
    output logic halt_exit,
    output logic clock_run,
    output logic periph_run,
    output logic watchdog_refresh,
    output logic device_reset_req,
    output logic debug_acknowledge,
    output logic irq
);
    typedef struct packed {
        logic booted;
        logic strap_entry;
        logic debug;
        logic bp_allow;
        logic ack;
        logic reset_pulse;
        logic nop_pulse;
        logic halt_pulse;
        logic [31:0] rdata;
    } ctl_state_t;

    ctl_state_t st_q, st_d;

    logic setup_phase;
    logic access_phase;
    logic addr_hit;
    logic wr_ctl;
    logic wr_status;
    logic wr_mask;
    logic bp_hit;
    logic strap_hit;
    logic sw_set;
    logic sw_clear;
    logic exec_busy;
    logic exec_dropped;
    logic [EV_COUNT-1:0] ev_set;
    logic [EV_COUNT-1:0] ev_status;
    logic [EV_COUNT-1:0] ev_mask;
    logic [7:0] ctl_view;
    logic [7:0] state_view;

    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign addr_hit = (paddr == ADDR_CONTROL) || (paddr == ADDR_IRQ_STATUS)
                   || (paddr == ADDR_IRQ_MASK) || (paddr == ADDR_STATE);
    // writes land on the completing access edge; pready is always high
    assign wr_ctl = access_phase && pwrite && (paddr == ADDR_CONTROL);
    assign wr_status = access_phase && pwrite && (paddr == ADDR_IRQ_STATUS);
    assign wr_mask = access_phase && pwrite && (paddr == ADDR_IRQ_MASK);

    assign bp_hit = opcode_decoded && (opcode == BREAKPOINT_OPCODE) && st_q.bp_allow; // R5 R10
    // the pin is judged at the first edge after release; the debugger keeps it low
    assign strap_hit = !st_q.booted && large_package && !debug_serial_pin_in; // R6 R7
    assign sw_set = wr_ctl && pwdata[CTL_DEBUG_BIT]; // R9
    assign sw_clear = wr_ctl && !pwdata[CTL_DEBUG_BIT] && !read_protect; // R9 R11

    // reserved bits are never stored and read as zero; reset request reads zero
    always_comb begin
        ctl_view = CTL_RESET;
        ctl_view[CTL_DEBUG_BIT] = st_q.debug;
        ctl_view[CTL_BP_ALLOW] = st_q.bp_allow;
        ctl_view[CTL_ACK] = st_q.ack;
        ctl_view[CTL_RSV_HI:CTL_RSV_LO] = '0; // R14
        ctl_view[CTL_RESET_REQ] = 1'b0;
    end

    always_comb begin
        state_view = 8'h00;
        state_view[ST_DEBUG] = st_q.debug;
        state_view[ST_PROTECT] = read_protect;
        state_view[ST_EXEC_BUSY] = exec_busy;
        state_view[ST_STOP] = stop_mode;
        state_view[ST_STRAP] = st_q.strap_entry;
    end

    always_comb begin
        st_d = st_q;
        st_d.booted = 1'b1;
        st_d.reset_pulse = 1'b0;
        st_d.nop_pulse = opcode_decoded && (opcode == BREAKPOINT_OPCODE) && !st_q.bp_allow; // R12
        if (strap_hit) begin
            st_d.strap_entry = 1'b1;
        end
        if (wr_ctl) begin
            st_d.bp_allow = pwdata[CTL_BP_ALLOW]; // R12
            st_d.ack = pwdata[CTL_ACK];
            st_d.reset_pulse = pwdata[CTL_RESET_REQ]; // R13
        end
        // a set from any source wins over a software clear in the same cycle
        if (sw_clear) begin
            st_d.debug = 1'b0; // R9
        end
        if (bp_hit || strap_hit || sw_set) begin
            st_d.debug = 1'b1; // R5 R6 R9 R10
        end
        st_d.halt_pulse = st_d.debug && !st_q.debug && halt_mode; // R3
        // read data is captured in the setup cycle, so it is a flop output
        if (setup_phase && !pwrite) begin
            case (paddr)
                ADDR_CONTROL: st_d.rdata = {24'h000000, ctl_view};
                ADDR_IRQ_STATUS: st_d.rdata = {{(32-EV_COUNT){1'b0}}, ev_status};
                ADDR_IRQ_MASK: st_d.rdata = {{(32-EV_COUNT){1'b0}}, ev_mask};
                ADDR_STATE: st_d.rdata = {24'h000000, state_view};
                default: st_d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '{booted: 1'b0, strap_entry: 1'b0, debug: 1'b0, bp_allow: 1'b0,
                      ack: 1'b0, reset_pulse: 1'b0, nop_pulse: 1'b0,
                      halt_pulse: 1'b0, rdata: 32'h00000000};
        end else begin
            st_q <= st_d;
        end
    end

    exec_gate u_exec_gate (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .exec_start(exec_start),
        .exec_len(exec_len),
        .exec_allowed(st_q.debug && !read_protect), // R8
        .byte_valid(exec_byte_valid),
        .byte_data(exec_byte),
        .busy(exec_busy),
        .core_valid(core_exec_valid),
        .core_byte(core_exec_byte),
        .core_last(core_exec_last),
        .discarded(exec_dropped)
    );

    always_comb begin
        ev_set = EV_RESET;
        ev_set[EV_ENTRY] = st_d.debug && !st_q.debug;
        ev_set[EV_DISCARD] = exec_dropped;
        ev_set[EV_RESET_REQ] = st_d.reset_pulse;
    end

    irq_flags #(
        .W(EV_COUNT)
    ) u_irq_flags (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .event_set(ev_set),
        .clear_ones(wr_status ? pwdata[EV_COUNT-1:0] : EV_RESET),
        .mask_write(wr_mask),
        .mask_wdata(pwdata[EV_COUNT-1:0]),
        .status(ev_status),
        .mask(ev_mask),
        .irq(irq)
    );

    assign prdata = st_q.rdata;
    assign pready = 1'b1;
    assign pslverr = access_phase && !addr_hit;

    assign fetch_stop = st_q.debug; // R1 R9
    assign core_idle = st_q.debug && !exec_busy; // R1
    assign breakpoint_as_nop = st_q.nop_pulse; // R12
    assign halt_exit = st_q.halt_pulse; // R3
    assign clock_run = !stop_mode; // R2
    assign periph_run = !stop_mode; // R2
    assign watchdog_refresh = st_q.debug && watchdog_enabled; // R4
    assign device_reset_req = st_q.reset_pulse; // R13
    assign debug_acknowledge = st_q.ack;

    sequence s_bp_seen;
        opcode_decoded && (opcode == BREAKPOINT_OPCODE) && st_q.bp_allow;
    endsequence
    property p_bp_enters;
        @(posedge clk_sys) disable iff (!rst_b)
        s_bp_seen |=> fetch_stop;
    endproperty
    a_bp_enters: assert property (p_bp_enters) else $error("breakpoint did not enter debug"); // R10

    property p_nop_when_disabled;
        @(posedge clk_sys) disable iff (!rst_b)
        opcode_decoded && (opcode == BREAKPOINT_OPCODE) && !st_q.bp_allow && !st_q.debug
            && !wr_ctl && !strap_hit |=> breakpoint_as_nop && !fetch_stop;
    endproperty
    a_nop_when_disabled: assert property (p_nop_when_disabled) else $error("opcode 00 not a no-op"); // R12

    property p_protect_holds;
        @(posedge clk_sys) disable iff (!rst_b)
        st_q.debug && read_protect |=> st_q.debug;
    endproperty
    a_protect_holds: assert property (p_protect_holds) else $error("debug bit cleared under protection"); // R11

    property p_clear_resumes;
        @(posedge clk_sys) disable iff (!rst_b)
        wr_ctl && !pwdata[CTL_DEBUG_BIT] && !read_protect && !bp_hit && !strap_hit
            |=> !fetch_stop && !watchdog_refresh;
    endproperty
    a_clear_resumes: assert property (p_clear_resumes) else $error("clear did not resume"); // R9

    property p_reset_request;
        @(posedge clk_sys) disable iff (!rst_b)
        wr_ctl && pwdata[CTL_RESET_REQ] |=> device_reset_req ##1 !device_reset_req;
    endproperty
    a_reset_request: assert property (p_reset_request) else $error("reset request not one pulse"); // R13

    property p_reserved_zero;
        @(posedge clk_sys) disable iff (!rst_b)
        setup_phase && !pwrite && (paddr == ADDR_CONTROL)
            |=> prdata[CTL_RSV_HI:CTL_RSV_LO] == '0 && prdata[CTL_DEBUG_BIT] == $past(st_q.debug);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("control readback wrong"); // R14

    property p_strap_entry;
        @(posedge clk_sys) disable iff (!rst_b)
        strap_hit |=> fetch_stop && st_q.strap_entry;
    endproperty
    a_strap_entry: assert property (p_strap_entry) else $error("strap did not enter debug"); // R6

    property p_watchdog_refresh;
        @(posedge clk_sys) disable iff (!rst_b)
        fetch_stop && watchdog_enabled |-> watchdog_refresh && (clock_run == !stop_mode);
    endproperty
    a_watchdog_refresh: assert property (p_watchdog_refresh) else $error("watchdog not refreshed"); // R4

    property p_halt_exit;
        @(posedge clk_sys) disable iff (!rst_b)
        ((!st_q.debug && halt_mode) and s_bp_seen) |=> halt_exit ##1 !halt_exit;
    endproperty
    a_halt_exit: assert property (p_halt_exit) else $error("halt not left on entry"); // R3
endmodule
`default_nettype wire

// file: inc/ocd_ctrl_pkg.sv
// constants shared by the debug control block and its helpers
// assumes a 32-bit APB master and an 8-bit core opcode decoder
package ocd_ctrl_pkg;
    // register byte addresses on APB
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0C;
    // debugger_control fields
    localparam int CTL_DEBUG_BIT = 7;
    localparam int CTL_BP_ALLOW = 6;
    localparam int CTL_ACK = 5;
    localparam int CTL_RSV_HI = 4;
    localparam int CTL_RSV_LO = 1;
    localparam int CTL_RESET_REQ = 0;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // read-only state register fields
    localparam int ST_DEBUG = 0;
    localparam int ST_PROTECT = 1;
    localparam int ST_EXEC_BUSY = 2;
    localparam int ST_STOP = 3;
    localparam int ST_STRAP = 4;
    // interrupt events
    localparam int EV_COUNT = 3;
    localparam int EV_ENTRY = 0;
    localparam int EV_DISCARD = 1;
    localparam int EV_RESET_REQ = 2;
    localparam logic [EV_COUNT-1:0] EV_RESET = 3'h0;
    // opcodes and execute command
    localparam logic [7:0] BREAKPOINT_OPCODE = 8'h00;
    localparam logic [7:0] EXEC_CMD_CODE = 8'h12;
    localparam logic [2:0] EXEC_LEN_MIN = 3'h1;
    localparam logic [2:0] EXEC_LEN_MAX = 3'h5;
endpackage

// file: testbench/debugger_model.sv
// behavioural external debugger: holds the debug pin at reset, sends execute commands
// assumes the serial line is already decoded into start, length and byte strobes
`timescale 1ns/100ps
`default_nettype none
module debugger_model
    import ocd_ctrl_pkg::*;
#(
    parameter int PIN_HOLD = 5000
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic strap_low,
    input wire logic send,
    input wire logic [2:0] len,
    input wire logic [3:0] gap,
    output logic debug_serial_pin_in,
    output logic exec_start,
    output logic [2:0] exec_len,
    output logic exec_byte_valid,
    output logic [7:0] exec_byte,
    output logic sending
);
    int hold_cnt;
    logic [2:0] left;
    logic [2:0] idx;
    logic [3:0] wait_cnt;

    // released pin floats to its pull-up; held low through reset and the hold time
    assign debug_serial_pin_in = (strap_low && hold_cnt < PIN_HOLD) ? 1'b0 : 1'b1;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            hold_cnt <= 0;
            exec_start <= 1'b0;
            exec_len <= 3'h1;
            exec_byte_valid <= 1'b0;
            exec_byte <= 8'h5A;
            left <= 3'h0;
            idx <= 3'h0;
            wait_cnt <= 4'h0;
            sending <= 1'b0;
        end else begin
            if (hold_cnt < PIN_HOLD) begin
                hold_cnt <= hold_cnt + 1;
            end
            exec_start <= 1'b0;
            exec_byte_valid <= 1'b0;
            // idle data keeps toggling so a stale byte is never mistaken for a fresh one
            exec_byte <= ~exec_byte;
            if (send && !sending) begin
                exec_start <= 1'b1;
                exec_len <= len;
                left <= len;
                idx <= 3'h0;
                wait_cnt <= gap;
                sending <= 1'b1;
            end else if (sending) begin
                if (wait_cnt != 4'h0) begin
                    wait_cnt <= wait_cnt - 4'h1;
                end else if (left != 3'h0) begin
                    exec_byte_valid <= 1'b1;
                    exec_byte <= 8'hA0 + {5'h00, idx};
                    idx <= idx + 3'h1;
                    left <= left - 3'h1;
                    wait_cnt <= gap;
                end else begin
                    sending <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: testbench/test_ocd_ctrl.sv
// self-checking bench for the debug state controller, APB master plus debugger model
// assumes zero or more wait states on APB and the debugger model on the execute port
`timescale 1ns/100ps
`default_nettype none
module test_ocd_ctrl
    import ocd_ctrl_pkg::*;
;
    logic clk_sys, rst_b, psel, penable, pwrite, large_package, read_protect;
    logic [7:0] paddr, opcode, exec_byte, core_exec_byte, last_b;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, opcode_decoded, halt_mode, stop_mode, watchdog_enabled;
    logic exec_start, exec_byte_valid, fetch_stop, core_idle, core_exec_valid;
    logic core_exec_last, breakpoint_as_nop, halt_exit, clock_run, periph_run;
    logic watchdog_refresh, device_reset_req, debug_acknowledge, irq, pin;
    logic strap_low, send, sending;
    logic [2:0] exec_len, len;
    logic [3:0] gap;
    int n_mismatch, checks_done, n_ev, n_last, n_nop, n_halt, n_rst;

    ocd_ctrl ocd_ctrl_i (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .debug_serial_pin_in(pin), .large_package(large_package),
        .read_protect(read_protect), .opcode_decoded(opcode_decoded), .opcode(opcode),
        .halt_mode(halt_mode), .stop_mode(stop_mode), .watchdog_enabled(watchdog_enabled),
        .exec_start(exec_start), .exec_len(exec_len), .exec_byte_valid(exec_byte_valid),
        .exec_byte(exec_byte), .fetch_stop(fetch_stop), .core_idle(core_idle),
        .core_exec_valid(core_exec_valid), .core_exec_byte(core_exec_byte),
        .core_exec_last(core_exec_last), .breakpoint_as_nop(breakpoint_as_nop),
        .halt_exit(halt_exit), .clock_run(clock_run), .periph_run(periph_run),
        .watchdog_refresh(watchdog_refresh), .device_reset_req(device_reset_req),
        .debug_acknowledge(debug_acknowledge), .irq(irq));

    debugger_model debugger_model_i (.clk_sys(clk_sys), .rst_b(rst_b), .strap_low(strap_low),
        .send(send), .len(len), .gap(gap), .debug_serial_pin_in(pin), .exec_start(exec_start),
        .exec_len(exec_len), .exec_byte_valid(exec_byte_valid), .exec_byte(exec_byte),
        .sending(sending));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (core_exec_valid === 1'b1) begin
            n_ev++;
            last_b = core_exec_byte;
        end
        if (core_exec_last === 1'b1) n_last++;
        if (breakpoint_as_nop === 1'b1) n_nop++;
        if (halt_exit === 1'b1) n_halt++;
        if (device_reset_req === 1'b1) n_rst++;
    end

    task automatic end_sim;
        if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            end_sim();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
    endtask

    task automatic do_reset(input logic s, input logic lp);
        strap_low <= s; large_package <= lp; rst_b <= 1'b0;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic decode(input logic [7:0] op);
        @(posedge clk_sys);
        opcode_decoded <= 1'b1; opcode <= op;
        @(posedge clk_sys);
        opcode_decoded <= 1'b0;
        #1;
    endtask

    task automatic run_exec(input logic [2:0] l);
        int n = 0;
        n_ev = 0; n_last = 0;
        @(posedge clk_sys);
        send <= 1'b1; len <= l; gap <= 4'h2;
        @(posedge clk_sys);
        send <= 1'b0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (sending === 1'b1 && n < 100);
        if (n >= 100) begin
            n_mismatch++;
            end_sim();
        end
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic t_strap;
        chk(fetch_stop, 1'b1);
        rd(ADDR_STATE, 32'h0000_0011);
        rd(ADDR_CONTROL, 32'h0000_0080);
        rd(ADDR_IRQ_MASK, 32'h0000_0000);
        rd(ADDR_IRQ_STATUS, 32'h0000_0001);
        chk(irq, 1'b0);
    endtask

    task automatic t_control;
        wr(ADDR_CONTROL, 32'h0000_0000);
        chk(fetch_stop, 1'b0);
        wr(ADDR_CONTROL, 32'hFFFF_FFFE);
        chk(fetch_stop, 1'b1);
        chk(debug_acknowledge, 1'b1);
        rd(ADDR_CONTROL, 32'h0000_00E0);
        wr(ADDR_CONTROL, 32'h0000_0000);
    endtask

    task automatic t_break;
        n_nop = 0; n_halt = 0;
        decode(BREAKPOINT_OPCODE);
        chk(fetch_stop, 1'b0);
        repeat (2) @(posedge clk_sys);
        chk(n_nop, 1);
        wr(ADDR_CONTROL, 32'h0000_0040);
        halt_mode <= 1'b1;
        decode(8'h0F);
        chk(fetch_stop, 1'b0);
        decode(BREAKPOINT_OPCODE);
        chk(fetch_stop, 1'b1);
        repeat (3) @(posedge clk_sys);
        chk(n_halt, 1);
        chk(n_nop, 1);
        halt_mode <= 1'b0;
        rd(ADDR_CONTROL, 32'h0000_00C0);
    endtask

    task automatic t_core;
        chk(core_idle, 1'b1);
        @(posedge clk_sys);
        watchdog_enabled <= 1'b1; stop_mode <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk(watchdog_refresh, 1'b1);
        chk({clock_run, periph_run}, 2'h0);
        watchdog_enabled <= 1'b0; stop_mode <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk(watchdog_refresh, 1'b0);
        chk({clock_run, periph_run}, 2'h3);
    endtask

    task automatic t_exec;
        wr(ADDR_IRQ_STATUS, 32'h0000_0007);
        run_exec(3'h2);
        chk(n_ev, 2);
        chk(n_last, 1);
        chk(last_b, 8'hA1);
        rd(ADDR_IRQ_STATUS, 32'h0000_0000);
        read_protect <= 1'b1;
        run_exec(3'h1);
        chk(n_ev, 0);
        rd(ADDR_IRQ_STATUS, 32'h0000_0002);
        read_protect <= 1'b0;
        wr(ADDR_IRQ_STATUS, 32'h0000_0002);
        wr(ADDR_CONTROL, 32'h0000_0040);
        run_exec(3'h1);
        chk(n_ev, 0);
        rd(ADDR_IRQ_STATUS, 32'h0000_0002);
    endtask

    task automatic t_irq_reset;
        logic [31:0] r;
        logic e;
        wr(ADDR_IRQ_MASK, 32'h0000_0007);
        chk(irq, 1'b1);
        wr(ADDR_IRQ_STATUS, 32'h0000_0007);
        chk(irq, 1'b0);
        n_rst = 0;
        wr(ADDR_CONTROL, 32'h0000_0041);
        repeat (2) @(posedge clk_sys);
        chk(n_rst, 1);
        rd(ADDR_IRQ_STATUS, 32'h0000_0004);
        rd(ADDR_CONTROL, 32'h0000_0040);
        chk(irq, 1'b1);
        wr(ADDR_IRQ_MASK, 32'h0000_0003);
        chk(irq, 1'b0);
        apb(1'b0, 8'h10, 32'h0000_0000, r, e);
        chk(r, 32'h0000_0000);
        chk(e, 1'b1);
    endtask

    task automatic t_protect;
        wr(ADDR_CONTROL, 32'h0000_0080);
        read_protect <= 1'b1;
        wr(ADDR_CONTROL, 32'h0000_0000);
        chk(fetch_stop, 1'b1);
        // small package ignores the pin strap, so only the reset clears debug here
        do_reset(1'b1, 1'b0);
        chk(fetch_stop, 1'b0);
        rd(ADDR_CONTROL, 32'h0000_0000);
        read_protect <= 1'b0;
    endtask

    initial begin
        rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0000_0000; large_package = 1'b1; read_protect = 1'b0;
        opcode_decoded = 1'b0; opcode = 8'h00; halt_mode = 1'b0; stop_mode = 1'b0;
        watchdog_enabled = 1'b0; strap_low = 1'b1; send = 1'b0; len = 3'h1; gap = 4'h0;
        n_mismatch = 0; checks_done = 0; last_b = 8'h00;
        do_reset(1'b1, 1'b1);
        t_strap();
        t_control();
        t_break();
        t_core();
        t_exec();
        t_irq_reset();
        t_protect();
        end_sim();
    end
endmodule
`default_nettype wire
